// *** dv/slcr_cable_model.sv ***
module slcr_cable_model
(
  // Clock
  input  wire logic                 clk_i,
  // Requested wire states
  input  wire slcr_pkg::slcr_wire_t minus_req_i,
  input  wire slcr_pkg::slcr_wire_t plus_req_i,
  // Monitor pins
  output slcr_pkg::slcr_wire_t      minus_wire_fault_o,
  output slcr_pkg::slcr_wire_t      plus_wire_fault_o
);
  timeunit 1ns;
  timeprecision 100ps;
  import slcr_pkg::*;

  // ==========================================================================
  // Pins
  // Off the falling edge, as a real monitor is not clock aligned
  always @(negedge clk_i)
  begin
    minus_wire_fault_o <= minus_req_i;
    plus_wire_fault_o  <= plus_req_i;
  end
endmodule : slcr_cable_model

// *** dv/slcr_regs_assertions.sv ***
module slcr_regs_checker
(
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  input wire logic                 ce_i,
  input wire logic                 cyc_i,
  input wire logic                 stb_i,
  input wire logic                 we_i,
  input wire logic [7:0]           adr_i,
  input wire logic [31:0]          dat_i,
  input wire logic [31:0]          dat_o,
  input wire logic                 ack_o,
  input wire logic                 err_o,
  input wire slcr_pkg::slcr_wire_t minus_wire_fault_i,
  input wire slcr_pkg::slcr_wire_t plus_wire_fault_i,
  input wire logic                 attention_o,
  input wire logic                 i2c_byte_vld_o,
  input wire logic                 i2c_done_o
);
  logic       supp;
  logic       ce_q;
  logic [2:0] pin_age;
  logic [3:0] pins_q;
  logic       wr_attn;
  logic       rd_ack;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  assign wr_attn = cyc_i && stb_i && we_i && adr_i == 8'h34;
  assign rd_ack  = ack_o && !we_i;

  // ==========================================================================
  // Suppress bit mirror; pin age hides the synchroniser delay
  always_ff @(posedge clk_i)
  begin
    pins_q <= {minus_wire_fault_i, plus_wire_fault_i};
    ce_q   <= ce_i;
    if (rst_i)
      supp <= 1'b0;
    else if (ack_o && we_i && adr_i == 8'h14 && ce_q)
      supp <= dat_i[7];
    if (rst_i || pins_q != {minus_wire_fault_i, plus_wire_fault_i})
      pin_age <= 3'h0;
    else if (pin_age != 3'h7)
      pin_age <= pin_age + 3'h1;
  end

  // ==========================================================================
  // Properties
  sequence s_lead_byte;
    i2c_byte_vld_o && !i2c_done_o;
  endsequence

  sequence s_last_byte;
    i2c_byte_vld_o && i2c_done_o;
  endsequence

  a_reg_sent: assert property ($rose(i2c_byte_vld_o) && !supp |->
    s_lead_byte ##1 s_lead_byte ##1 s_last_byte) else $error("register byte missing");
  a_cmd_only: assert property ($rose(i2c_byte_vld_o) && supp |->
    s_lead_byte ##1 s_last_byte) else $error("register byte not suppressed");
  // Writes taken while the clock enable was low are dropped
  a_attn_rise: assert property (wr_attn && ack_o && ce_q && dat_i[7] |=> attention_o)
    else $error("attention not raised");
  a_attn_fall: assert property (wr_attn && ack_o && ce_q && !dat_i[7] |=> !attention_o)
    else $error("attention not lowered");
  a_attn_cause: assert property ($changed(attention_o) |-> $past(wr_attn))
    else $error("attention moved without a write");
  a_attn_read: assert property (rd_ack && adr_i == 8'h34 |->
    dat_o == {24'h0, attention_o, 7'h0f}) else $error("attention register value");
  a_cable_read: assert property (rd_ack && adr_i == 8'h20 && pin_age == 3'h7 |->
    dat_o == {28'h0, pins_q}) else $error("cable status value");
  a_rsvd_fixed: assert property (rd_ack && (adr_i == 8'h18 || adr_i == 8'h1c) |->
    dat_o == (adr_i[2] ? 32'h22 : 32'h40)) else $error("reserved register changed");
  a_bus_answer: assert property (cyc_i && stb_i && !ack_o && !err_o |=> ack_o ^ err_o)
    else $error("bus request not answered");
endmodule : slcr_regs_checker

// *** dv/slcr_regs_test.sv ***
`include "slcr_map.svh"
`define CHK(nm, exp, got) begin comparisons++; if ((got) !== (exp)) begin n_errors++; \
  $display("MISMATCH %s expected %h seen %h", nm, exp, got); end end

module slcr_regs_test;
  timeunit 1ns;
  timeprecision 100ps;
  import slcr_pkg::*;

  logic        clk_i = 1'b0;
  logic        rst_i;
  logic        ce_i;
  logic        cyc_i;
  logic        stb_i;
  logic        we_i;
  logic [7:0]  adr_i;
  logic [3:0]  sel_i;
  logic [31:0] dat_i;
  logic [31:0] dat_o;
  logic        ack_o;
  logic        err_o;
  slcr_wire_t  minus_wire_fault_i;
  slcr_wire_t  plus_wire_fault_i;
  slcr_wire_t  minus_req;
  slcr_wire_t  plus_req;
  logic        attention_o;
  logic        i2c_byte_vld_o;
  logic [7:0]  i2c_byte_o;
  logic        i2c_done_o;
  logic        irq_o;
  int          n_errors = 0;
  int          comparisons = 0;

  always #12.5 clk_i = ~clk_i;

  slcr_regs slcr_regs_inst (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i, .we_i, .adr_i,
    .sel_i, .dat_i, .dat_o, .ack_o, .err_o, .minus_wire_fault_i, .plus_wire_fault_i,
    .attention_o, .i2c_byte_vld_o, .i2c_byte_o, .i2c_done_o, .irq_o);
  slcr_cable_model slcr_cable_model_inst (.clk_i, .minus_req_i(minus_req),
    .plus_req_i(plus_req), .minus_wire_fault_o(minus_wire_fault_i),
    .plus_wire_fault_o(plus_wire_fault_i));

  // ==========================================================================
  // Bus tasks
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                    output logic [31:0] rd, output logic erred);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= we;
    adr_i <= adr;
    dat_i <= wd;
    // Only the watchdog ends a wait for the answer
    do
    begin
      @(posedge clk_i);
    end
    while (ack_o !== 1'b1 && err_o !== 1'b1);
    rd = dat_o;
    erred = err_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask : wb

  task automatic wr(input logic [7:0] adr, input logic [31:0] wd);
    logic [31:0] rd;
    logic        e;
    wb(1'b1, adr, wd, rd, e);
  endtask : wr

  task automatic rdc(input string nm, input logic [7:0] adr, input logic [31:0] exp);
    logic [31:0] rd;
    logic        e;
    wb(1'b0, adr, 32'h0, rd, e);
    `CHK(nm, exp, rd)
  endtask : rdc

  // ==========================================================================
  // Scenarios
  task automatic test_reset;
    rdc("out_cfg", 8'h14, {24'h0, `SLCR_RST_OUT_CFG});
    rdc("cable", 8'h20, 32'h0a);
    rdc("attn", 8'h34, 32'h0f);
    rdc("part", 8'h78, {24'h0, `SLCR_PART_CODE});
    rdc("rev", 8'h7c, {28'h0, `SLCR_PART_REV});
  endtask : test_reset

  task automatic test_reserved;
    wr(8'h18, 32'hff);
    wr(8'h1c, 32'h00);
    wr(8'h34, 32'h7f);
    wr(8'h78, 32'h00);
    rdc("rsvd_a", 8'h18, 32'h40);
    rdc("rsvd_b", 8'h1c, 32'h22);
    rdc("attn_low", 8'h34, 32'h0f);
    rdc("part", 8'h78, {24'h0, `SLCR_PART_CODE});
  endtask : test_reserved

  task automatic test_attention;
    wr(8'h84, 32'h2);
    wr(8'h34, 32'h80);
    repeat (2) @(posedge clk_i);
    `CHK("attention", 1'b1, attention_o)
    `CHK("irq", 1'b1, irq_o)
    rdc("attn_reg", 8'h34, 32'h8f);
    rdc("irq_stat", 8'h80, 32'h2);
    wr(8'h88, 32'h2);
    repeat (2) @(posedge clk_i);
    `CHK("irq_clr", 1'b0, irq_o)
    wr(8'h84, 32'h0);
    wr(8'h34, 32'h0);
    repeat (2) @(posedge clk_i);
    `CHK("attention", 1'b0, attention_o)
    `CHK("irq_mask", 1'b0, irq_o)
    rdc("irq_stat", 8'h80, 32'h2);
    wr(8'h88, 32'h2);
  endtask : test_attention

  task automatic test_convert(input logic supp);
    logic [7:0] q[$];
    int         n;
    n = 0;
    wr(8'h14, {24'h0, supp, 7'h70});
    wr(8'h8c, 32'h81a53cc3);
    do
    begin
      @(posedge clk_i);
      n++;
      if (i2c_byte_vld_o === 1'b1)
        q.push_back(i2c_byte_o);
    end
    while (i2c_done_o !== 1'b1 && n < 20);
    `CHK("byte_count", supp ? 3'd2 : 3'd3, 3'(q.size()))
    `CHK("dev_byte", 8'ha5, q[0])
    `CHK("cmd_byte", 8'hc3, q[q.size() - 1])
    if (!supp)
      `CHK("reg_byte", 8'h3c, q[1])
  endtask : test_convert

  task automatic test_cable;
    for (int i = 0; i < 4; i++)
    begin
      minus_req <= slcr_wire_t'(i);
      plus_req  <= slcr_wire_t'(3 - i);
      repeat (8) @(posedge clk_i);
      rdc("cable", 8'h20, {28'h0, 2'(i), 2'(3 - i)});
    end
  endtask : test_cable

  task automatic test_unmapped;
    logic [31:0] rd;
    logic        e;
    wb(1'b0, 8'h40, 32'h0, rd, e);
    `CHK("err_unmapped", 1'b1, e)
    wb(1'b1, 8'h15, 32'h80, rd, e);
    `CHK("err_misaligned", 1'b1, e)
    rdc("out_cfg", 8'h14, 32'hf0);
  endtask : test_unmapped

  // Bus still answers while frozen, but the write is dropped
  task automatic test_freeze;
    ce_i <= 1'b0;
    wr(8'h34, 32'h80);
    repeat (2) @(posedge clk_i);
    `CHK("attention_frozen", 1'b0, attention_o)
    rdc("attn_frozen", 8'h34, 32'h0f);
    ce_i <= 1'b1;
  endtask : test_freeze

  task automatic test_midreset;
    wr(8'h34, 32'h80);
    `CHK("attention_set", 1'b1, attention_o)
    rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    `CHK("attention_rst", 1'b0, attention_o)
    rdc("out_cfg_rst", 8'h14, {24'h0, `SLCR_RST_OUT_CFG});
    rdc("attn_rst", 8'h34, 32'h0f);
  endtask : test_midreset

  // ==========================================================================
  // Run control
  task automatic wrap_up;
    if (n_errors == 0 && comparisons > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : wrap_up

  initial
  begin
    rst_i = 1'b1;
    ce_i = 1'b1;
    cyc_i = 1'b0;
    stb_i = 1'b0;
    we_i = 1'b0;
    adr_i = 8'h0;
    sel_i = 4'hf;
    dat_i = 32'h0;
    minus_req = SLCR_WIRE_NORMAL;
    plus_req = SLCR_WIRE_NORMAL;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    test_reset();
    test_reserved();
    test_attention();
    test_convert(1'b0);
    test_convert(1'b1);
    test_cable();
    test_unmapped();
    test_freeze();
    test_midreset();
    wrap_up();
  end

  // Whole run is a few hundred cycles
  initial
  begin
    repeat (20000) @(posedge clk_i);
    n_errors++;
    wrap_up();
  end
endmodule : slcr_regs_test

bind slcr_regs slcr_regs_checker slcr_regs_checker_inst (.clk_i, .rst_i, .ce_i, .cyc_i, .stb_i,
  .we_i, .adr_i, .dat_i, .dat_o, .ack_o, .err_o, .minus_wire_fault_i, .plus_wire_fault_i,
  .attention_o, .i2c_byte_vld_o, .i2c_done_o);

// *** rtl/slcr_i2c_conv.sv ***
`include "slcr_map.svh"

module slcr_i2c_conv
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  // Request
  input  wire logic       start_i,
  input  wire logic       suppress_i,
  input  wire logic [7:0] dev_i,
  input  wire logic [7:0] reg_i,
  input  wire logic [7:0] cmd_i,
  output logic            busy_o,
  // Byte stream
  output logic            byte_vld_o,
  output logic [7:0]      byte_o,
  output logic            done_o
);
  import slcr_pkg::*;

  slcr_cv_state_t state;
  slcr_cv_state_t next_state;
  logic [7:0]     next_byte;
  logic           next_vld;
  logic           next_done;
  logic           supp;
  logic           next_supp;

  always_comb
  begin
    next_state = state;
    next_byte  = byte_o;
    next_vld   = 1'b0;
    next_done  = 1'b0;
    next_supp  = supp;
    if (ce_i)
    begin
      unique case (state)
        SLCR_CV_IDLE:
          if (start_i)
          begin
            next_supp  = suppress_i;
            next_state = SLCR_CV_DEV;
          end
        SLCR_CV_DEV:
        begin
          next_byte  = dev_i;
          next_vld   = 1'b1;
          // Suppression skips the register address byte
          next_state = supp ? SLCR_CV_CMD : SLCR_CV_REG;
        end
        SLCR_CV_REG:
        begin
          next_byte  = reg_i;
          next_vld   = 1'b1;
          next_state = SLCR_CV_CMD;
        end
        SLCR_CV_CMD:
        begin
          next_byte  = cmd_i;
          next_vld   = 1'b1;
          next_done  = 1'b1;
          next_state = SLCR_CV_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state      <= SLCR_CV_IDLE;
      byte_o     <= 8'h00;
      byte_vld_o <= 1'b0;
      done_o     <= 1'b0;
      supp       <= 1'b0;
    end
    else
    begin
      state      <= next_state;
      byte_o     <= next_byte;
      byte_vld_o <= next_vld;
      done_o     <= next_done;
      supp       <= next_supp;
    end
  end

  assign busy_o = (state != SLCR_CV_IDLE);

endmodule : slcr_i2c_conv

// *** rtl/slcr_map.svh ***
`ifndef SLCR_MAP_SVH
`define SLCR_MAP_SVH

// ==========================================================================
// Register indices; the bus byte address is the index times four
`define SLCR_IDX_OUT_CFG    8'h05
`define SLCR_IDX_RSVD_A     8'h06
`define SLCR_IDX_RSVD_B     8'h07
`define SLCR_IDX_CABLE      8'h08
`define SLCR_IDX_ATTN       8'h0d
`define SLCR_IDX_PART       8'h1e
`define SLCR_IDX_REV        8'h1f
`define SLCR_IDX_IRQ_STAT   8'h20
`define SLCR_IDX_IRQ_EN     8'h21
`define SLCR_IDX_IRQ_CLR    8'h22
`define SLCR_IDX_I2C_REQ    8'h23

// ==========================================================================
// Field positions
`define SLCR_BIT_ADDR_SUPP  7
`define SLCR_BIT_ATTN       7

// ==========================================================================
// Reset values
`define SLCR_RST_OUT_CFG    8'h70
`define SLCR_RST_RSVD_A     8'h40
`define SLCR_RST_RSVD_B     8'h22
`define SLCR_RST_ATTN_LOW   7'h0f
`define SLCR_RST_WIRE       2'h2

// ==========================================================================
// Identity values, arbitrary
`define SLCR_PART_CODE      8'h5a
`define SLCR_PART_REV       4'h3

`endif

// *** rtl/slcr_pkg.sv ***
package slcr_pkg;

  // ==========================================================================
  // Cable wire condition
  typedef enum logic [1:0]
  {
    SLCR_WIRE_BATT   = 2'h0,
    SLCR_WIRE_GND    = 2'h1,
    SLCR_WIRE_NORMAL = 2'h2,
    SLCR_WIRE_OPEN   = 2'h3
  } slcr_wire_t;

  // ==========================================================================
  // I2C conversion sequencer states (Gray along the unsuppressed path)
  typedef enum logic [1:0]
  {
    SLCR_CV_IDLE = 2'b00,
    SLCR_CV_DEV  = 2'b01,
    SLCR_CV_REG  = 2'b11,
    SLCR_CV_CMD  = 2'b10
  } slcr_cv_state_t;

endpackage : slcr_pkg

// *** rtl/slcr_regs.sv ***
`include "slcr_map.svh"

module slcr_regs
(
  // Clock, reset, enable
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // Wishbone slave
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [7:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             err_o,
  // Cable monitor pins
  input  wire slcr_pkg::slcr_wire_t minus_wire_fault_i,
  input  wire slcr_pkg::slcr_wire_t plus_wire_fault_i,
  // Remote attention
  output logic             attention_o,
  // I2C conversion byte stream
  output logic             i2c_byte_vld_o,
  output logic [7:0]       i2c_byte_o,
  output logic             i2c_done_o,
  // Interrupt
  output logic             irq_o
);
  import slcr_pkg::*;

  // ==========================================================================
  // Address decode
  function automatic logic hit(input logic [7:0] adr, input logic [7:0] idx);
    hit = (adr[7:2] == idx[5:0]) && (adr[1:0] == 2'b00);
  endfunction : hit

  logic [7:0]  out_cfg;
  logic [7:0]  next_out_cfg;
  logic        attention_request_bit;
  logic        next_attention_request_bit;
  logic        next_attention;
  logic [3:0]  wire_sync;
  logic [3:0]  wire_prev;
  logic [2:0]  irq_stat;
  logic [2:0]  next_irq_stat;
  logic [2:0]  irq_en;
  logic [2:0]  next_irq_en;
  logic        next_irq;
  logic [23:0] i2c_req;
  logic [23:0] next_i2c_req;
  logic        conv_start;
  logic        next_conv_start;
  logic        conv_busy;
  logic        conv_vld;
  logic [7:0]  conv_byte;
  logic        conv_done;
  logic [31:0] next_dat;
  logic        next_ack;
  logic        next_err;
  logic        req;
  logic        wr_lane0;
  logic [7:0]  cable_byte;
  logic [2:0]  events;
  logic        mapped;

  // ==========================================================================
  // Cable inputs are asynchronous pins
  slcr_sync2 u_sync
  (
    .clk_i (clk_i),
    .rst_i (rst_i),
    .ce_i  (ce_i),
    .d_i   ({minus_wire_fault_i, plus_wire_fault_i}),
    .q_o   (wire_sync)
  );

  // ==========================================================================
  // Conversion sequencer
  slcr_i2c_conv u_conv
  (
    .clk_i      (clk_i),
    .rst_i      (rst_i),
    .ce_i       (ce_i),
    .start_i    (conv_start),
    .suppress_i (out_cfg[`SLCR_BIT_ADDR_SUPP]),
    .dev_i      (i2c_req[23:16]),
    .reg_i      (i2c_req[15:8]),
    .cmd_i      (i2c_req[7:0]),
    .busy_o     (conv_busy),
    .byte_vld_o (conv_vld),
    .byte_o     (conv_byte),
    .done_o     (conv_done)
  );

  // ==========================================================================
  // Bus and register next state
  assign req        = cyc_i && stb_i && !ack_o && !err_o;
  assign wr_lane0   = req && we_i && sel_i[0];
  assign cable_byte = {4'h0, wire_sync};
  assign mapped     = hit(adr_i, `SLCR_IDX_OUT_CFG) || hit(adr_i, `SLCR_IDX_RSVD_A)
                   || hit(adr_i, `SLCR_IDX_RSVD_B) || hit(adr_i, `SLCR_IDX_CABLE)
                   || hit(adr_i, `SLCR_IDX_ATTN) || hit(adr_i, `SLCR_IDX_PART)
                   || hit(adr_i, `SLCR_IDX_REV) || hit(adr_i, `SLCR_IDX_IRQ_STAT)
                   || hit(adr_i, `SLCR_IDX_IRQ_EN) || hit(adr_i, `SLCR_IDX_IRQ_CLR)
                   || hit(adr_i, `SLCR_IDX_I2C_REQ);
  // Events: cable state change, attention edge, conversion done
  assign events     = {conv_done,
                       next_attention != attention_request_bit,
                       wire_sync != wire_prev};

  always_comb
  begin
    next_out_cfg               = out_cfg;
    next_attention_request_bit = attention_request_bit;
    next_irq_en                = irq_en;
    next_i2c_req               = i2c_req;
    next_conv_start            = 1'b0;
    next_dat                   = 32'h0000_0000;
    next_ack                   = 1'b0;
    next_err                   = 1'b0;
    next_irq_stat              = irq_stat;
    if (req)
    begin
      next_ack = mapped;
      next_err = !mapped;
      if (!we_i)
      begin
        if (hit(adr_i, `SLCR_IDX_OUT_CFG))
          next_dat[7:0] = out_cfg;
        if (hit(adr_i, `SLCR_IDX_RSVD_A))
          next_dat[7:0] = `SLCR_RST_RSVD_A;
        if (hit(adr_i, `SLCR_IDX_RSVD_B))
          next_dat[7:0] = `SLCR_RST_RSVD_B;
        if (hit(adr_i, `SLCR_IDX_CABLE))
          next_dat[7:0] = cable_byte;
        if (hit(adr_i, `SLCR_IDX_ATTN))
          next_dat[7:0] = {attention_request_bit, `SLCR_RST_ATTN_LOW};
        if (hit(adr_i, `SLCR_IDX_PART))
          next_dat[7:0] = `SLCR_PART_CODE;
        if (hit(adr_i, `SLCR_IDX_REV))
          next_dat[7:0] = {4'h0, `SLCR_PART_REV};
        if (hit(adr_i, `SLCR_IDX_IRQ_STAT))
          next_dat[2:0] = irq_stat;
        if (hit(adr_i, `SLCR_IDX_IRQ_EN))
          next_dat[2:0] = irq_en;
        if (hit(adr_i, `SLCR_IDX_I2C_REQ))
          next_dat[24:0] = {conv_busy, i2c_req};
      end
      else
      begin
        // Only defined fields take write data; reserved bits stay put
        if (wr_lane0 && hit(adr_i, `SLCR_IDX_OUT_CFG))
          next_out_cfg = dat_i[7:0];
        if (wr_lane0 && hit(adr_i, `SLCR_IDX_ATTN))
          next_attention_request_bit = dat_i[`SLCR_BIT_ATTN];
        if (wr_lane0 && hit(adr_i, `SLCR_IDX_IRQ_EN))
          next_irq_en = dat_i[2:0];
        if (wr_lane0 && hit(adr_i, `SLCR_IDX_IRQ_CLR))
          next_irq_stat = irq_stat & ~dat_i[2:0];
        // Request ignored while a conversion is running
        if (hit(adr_i, `SLCR_IDX_I2C_REQ) && !conv_busy)
        begin
          if (sel_i[0])
            next_i2c_req[7:0] = dat_i[7:0];
          if (sel_i[1])
            next_i2c_req[15:8] = dat_i[15:8];
          if (sel_i[2])
            next_i2c_req[23:16] = dat_i[23:16];
          next_conv_start = sel_i[3] && dat_i[31];
        end
      end
    end
    if (!ce_i)
    begin
      next_out_cfg               = out_cfg;
      next_attention_request_bit = attention_request_bit;
      next_irq_en                = irq_en;
      next_i2c_req               = i2c_req;
      next_irq_stat              = irq_stat;
    end
    // Set wins over a clear in the same cycle
    if (ce_i)
      next_irq_stat = next_irq_stat | events;
    // Line follows the bit's edges: rise sets high, fall sets low
    next_attention = next_attention_request_bit;
    next_irq       = |(next_irq_stat & next_irq_en);
  end

  // ==========================================================================
  // Registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      out_cfg               <= `SLCR_RST_OUT_CFG;
      attention_request_bit <= 1'b0;
      attention_o           <= 1'b0;
      irq_stat              <= 3'h0;
      irq_en                <= 3'h0;
      irq_o                 <= 1'b0;
      i2c_req               <= 24'h00_0000;
      conv_start            <= 1'b0;
      wire_prev             <= {`SLCR_RST_WIRE, `SLCR_RST_WIRE};
      dat_o                 <= 32'h0000_0000;
      ack_o                 <= 1'b0;
      err_o                 <= 1'b0;
      i2c_byte_vld_o        <= 1'b0;
      i2c_byte_o            <= 8'h00;
      i2c_done_o            <= 1'b0;
    end
    else
    begin
      out_cfg               <= next_out_cfg;
      attention_request_bit <= next_attention_request_bit;
      attention_o           <= next_attention;
      irq_stat              <= next_irq_stat;
      irq_en                <= next_irq_en;
      irq_o                 <= next_irq;
      i2c_req               <= next_i2c_req;
      conv_start            <= ce_i ? next_conv_start : conv_start;
      wire_prev             <= ce_i ? wire_sync : wire_prev;
      dat_o                 <= next_dat;
      ack_o                 <= next_ack;
      err_o                 <= next_err;
      i2c_byte_vld_o        <= conv_vld;
      i2c_byte_o            <= conv_byte;
      i2c_done_o            <= conv_done;
    end
  end

endmodule : slcr_regs

// *** rtl/slcr_sync2.sv ***
module slcr_sync2
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       ce_i,
  // Data
  input  wire logic [3:0] d_i,
  output logic      [3:0] q_o
);

  logic [3:0] meta;
  logic [3:0] next_meta;
  logic [3:0] next_q;

  always_comb
  begin
    next_meta = meta;
    next_q    = q_o;
    if (ce_i)
    begin
      next_meta = d_i;
      next_q    = meta;
    end
  end

  // Resets to normal wire condition on both wires
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      meta <= 4'ha;
      q_o  <= 4'ha;
    end
    else
    begin
      meta <= next_meta;
      q_o  <= next_q;
    end
  end

endmodule : slcr_sync2
